// ---- ugc_defines.svh ----
// Contract
// [RQ1] CPU writes endpoint select 0-7 first.
// [RQ2] Direction bit: zero OUT, one IN.
// [RQ3] Each SOF loads 11-bit frame number.
// [RQ4] Frame split low/high; high top bits zero.
// [RQ5] Missed SOF increments stored frame count.
// [RQ6] Internal increment wraps at eleven bits.
// [RQ7] Host address captured, bit seven reads zero.
// [RQ8] Answer only tokens to own address.
// [RQ9] Re-enumeration clears address to zero.
// [RQ10] Empty iso IN, flag clear: no response.
// [RQ11] Empty iso IN, flag set: zero-length packet.
// [RQ12] Bits five-three pair bulk OUT endpoints.
// [RQ13] Bits two-zero pair bulk IN endpoints.
// [RQ14] Even endpoint busy/irq look single-buffered.
// [RQ15] CPU leaves paired odd endpoint unused.
// [RQ16] Even OUT byte count write switches buffers.
// [RQ17] Invalid endpoint gets no response at all.
// [RQ18] Enable bits reset to default configuration.
`ifndef UGC_DEFINES_SVH
`define UGC_DEFINES_SVH

// Register byte addresses on the CPU port.
`define UGC_ADDR_TOGGLE_CTL     16'h7fd7
`define UGC_ADDR_FRAME_LOW      16'h7fd8
`define UGC_ADDR_FRAME_HIGH     16'h7fd9
`define UGC_ADDR_DEV_ADDR       16'h7fdb
`define UGC_ADDR_PAIR_CTL       16'h7fdd
`define UGC_ADDR_BULK_IN_EN     16'h7fde
`define UGC_ADDR_BULK_OUT_EN    16'h7fdf
`define UGC_ADDR_ISO_IN_EN      16'h7fe0

// Reset values.
`define UGC_RST_BULK_IN_EN      8'h57
`define UGC_RST_BULK_OUT_EN     8'h55
`define UGC_RST_ISO_IN_EN       8'h07
`define UGC_RST_PAIR_CTL        8'h00
`define UGC_RST_FRAME           11'h000
`define UGC_RST_DEV_ADDR        7'h00

// Field positions and pair count.
`define UGC_PAIR_ZLP_BIT        7
`define UGC_PAIR_SPARE_BIT      6
`define UGC_TOG_VALUE_BIT       7
`define UGC_TOG_SET_BIT         6
`define UGC_TOG_CLR_BIT         5
`define UGC_TOG_DIR_BIT         4
`define UGC_NUM_PAIRS           6

`endif

// ---- ugc_pkg.sv ----
package ugc_pkg;

  // Kind of answer given to a token.
  typedef enum logic [1:0] {
    UGC_RESP_IGNORE,
    UGC_RESP_SILENT,
    UGC_RESP_ZLP,
    UGC_RESP_NORMAL
  } ugc_resp_kind_t;

  // Frame marker from the packet decoder.
  typedef struct packed {
    logic        valid;
    logic        missed;
    logic [10:0] frame;
  } ugc_sof_t;

  // Address assignment and re-enumeration events.
  typedef struct packed {
    logic       set_valid;
    logic [6:0] set_addr;
    logic       renum;
  } ugc_addr_evt_t;

  // Decoded token to be judged.
  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
    logic [3:0] ep;
    logic       is_in;
    logic       fifo_empty;
  } ugc_tok_t;

  // Verdict on the last token.
  typedef struct packed {
    logic           done;
    ugc_resp_kind_t kind;
  } ugc_resp_t;

  // Bulk endpoint event: transfer done or byte count written.
  typedef struct packed {
    logic       valid;
    logic       is_in;
    logic [2:0] ep;
  } ugc_ep_evt_t;

  // Data toggle command to the toggle store.
  typedef struct packed {
    logic       set;
    logic       clear;
    logic       is_in;
    logic [2:0] ep;
  } ugc_tog_t;

  // State of one ping-pong buffer pair.
  typedef struct packed {
    logic [1:0] full;
    logic       prod_ptr;
    logic       cons_ptr;
    logic       avail;
    logic       space;
  } ugc_pair_state_t;

endpackage

// ---- ugc_pair_buf.sv ----
`timescale 1ns/100ps
`include "ugc_defines.svh"
module ugc_pair_buf (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Pair control and events.
  input  wire logic enable,
  input  wire logic produce,
  input  wire logic consume,
  // Registered status.
  output logic      avail,
  output logic      space,
  output logic      prod_buf,
  output logic      cons_buf
);

  ugc_pkg::ugc_pair_state_t st;       // Current state.
  ugc_pkg::ugc_pair_state_t next_st;  // Next state.

  // Producer fills the buffer it points at, consumer drains its own; each flips on use.
  always_comb begin
    next_st = st;
    if (!enable) begin
      // A disabled pair holds no data and offers room.
      next_st.full     = 2'h0;
      next_st.prod_ptr = 1'b0;
      next_st.cons_ptr = 1'b0;
    end else begin
      if (produce && !st.full[st.prod_ptr]) begin
        next_st.full[st.prod_ptr] = 1'b1;
        next_st.prod_ptr          = ~st.prod_ptr;
      end
      if (consume && st.full[st.cons_ptr]) begin
        next_st.full[st.cons_ptr] = 1'b0; // [RQ16]
        next_st.cons_ptr          = ~st.cons_ptr; // [RQ16]
      end
    end
    next_st.avail = next_st.full[next_st.cons_ptr];
    next_st.space = ~next_st.full[next_st.prod_ptr];
  end

  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '{full: 2'h0, prod_ptr: 1'b0, cons_ptr: 1'b0, avail: 1'b0, space: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign avail    = st.avail;
  assign space    = st.space;
  assign prod_buf = st.prod_ptr;
  assign cons_buf = st.cons_ptr;

endmodule

// ---- ugc_global_ctl.sv ----
`timescale 1ns/100ps
`include "ugc_defines.svh"
module ugc_global_ctl #(
  parameter int ADDR_W = 16
) (
  // Clock and reset.
  input  wire logic                   CORE_CLK,
  input  wire logic                   RST_N,
  // CPU register port.
  input  wire logic [ADDR_W-1:0]      REG_ADDR,
  input  wire logic [7:0]             REG_WDATA,
  input  wire logic                   REG_WR,
  input  wire logic                   REG_RD,
  output logic      [7:0]             REG_RDATA,
  // Frame and address events from the packet decoder.
  input  wire ugc_pkg::ugc_sof_t      SOF,
  input  wire ugc_pkg::ugc_addr_evt_t ADDR_EVT,
  // Token judgement.
  input  wire ugc_pkg::ugc_tok_t      TOK,
  output ugc_pkg::ugc_resp_t          RESP,
  // Bulk transfer completions and byte count writes.
  input  wire ugc_pkg::ugc_ep_evt_t   XFER_DONE,
  input  wire ugc_pkg::ugc_ep_evt_t   BC_WRITE,
  // Pair status, index 0-2 IN pairs, 3-5 OUT pairs.
  output logic      [5:0]             PAIR_CPU_BUSY,
  output logic      [5:0]             PAIR_CPU_IRQ,
  output logic      [5:0]             PAIR_USB_NAK,
  output logic      [5:0]             PAIR_CPU_BUF,
  output logic      [5:0]             PAIR_USB_BUF,
  // Data toggle store.
  input  wire logic                   TOGGLE_VALUE,
  output ugc_pkg::ugc_tog_t           TOGGLE
);

  // The decode compares the low 16 bits of the port address.
  if (ADDR_W < 16) begin : g_chk
    $error("ADDR_W must be at least 16");
  end

  // All module state in one record.
  typedef struct packed {
    logic [10:0]        frame;      // Frame number.
    logic [6:0]         dev_addr;   // Assigned device address.
    logic [7:0]         pair_ctl;   // Zero-length flag, spare, pair enables.
    logic [7:0]         bulk_in;    // Bulk IN enables.
    logic [7:0]         bulk_out;   // Bulk OUT enables.
    logic [7:0]         iso_in;     // Iso IN enables.
    logic               tog_dir;    // Toggle select direction.
    logic [2:0]         tog_ep;     // Toggle select endpoint.
    ugc_pkg::ugc_tog_t  tog;        // Toggle command outputs.
    ugc_pkg::ugc_resp_t resp;       // Token verdict outputs.
    logic [7:0]         rdata;      // Read data.
    logic [5:0]         busy;       // CPU busy per pair.
    logic [5:0]         irq;        // CPU ready pulse per pair.
    logic [5:0]         nak;        // USB refuse per pair.
  } ugc_state_t;

  ugc_state_t st;       // Current state.
  ugc_state_t next_st;  // Next state.

  logic [5:0] cpu_ready;  // Pair has something for the CPU side.
  logic [5:0] usb_ready;  // Pair can serve the USB side.
  logic [5:0] prod_buf;   // Producer buffer per pair.
  logic [5:0] cons_buf;   // Consumer buffer per pair.
  logic [5:0] pair_avail; // Data waiting per pair.
  logic [5:0] pair_space; // Room left per pair.
  logic       ep_enabled; // Addressed endpoint is enabled.
  logic [7:0] wsel;       // Write strobe per register.

  // Per-pair ping-pong trackers; IN pairs are filled by the CPU, OUT pairs by USB.
  for (genvar g = 0; g < `UGC_NUM_PAIRS; g++) begin : g_pair
    localparam logic [2:0] EVEN_EP = 3'((g % 3) * 2 + 2);
    localparam logic       IS_IN   = (g < 3);
    logic bc_hit;
    logic xf_hit;
    assign bc_hit = BC_WRITE.valid && (BC_WRITE.is_in == IS_IN) && (BC_WRITE.ep == EVEN_EP);
    assign xf_hit = XFER_DONE.valid && (XFER_DONE.is_in == IS_IN) && (XFER_DONE.ep == EVEN_EP);
    ugc_pair_buf u_buf (
      .clk      (CORE_CLK),
      .rst_n    (RST_N),
      .enable   (st.pair_ctl[g]), // [RQ12] [RQ13]
      .produce  (IS_IN ? bc_hit : xf_hit),
      .consume  (IS_IN ? xf_hit : bc_hit), // [RQ16]
      .avail    (pair_avail[g]),
      .space    (pair_space[g]),
      .prod_buf (prod_buf[g]),
      .cons_buf (cons_buf[g])
    );
    // CPU side owns the producer end of IN pairs and the consumer end of OUT pairs.
    if (IS_IN) begin : g_in
      assign cpu_ready[g]    = pair_space[g];
      assign usb_ready[g]    = pair_avail[g];
      assign PAIR_CPU_BUF[g] = prod_buf[g];
      assign PAIR_USB_BUF[g] = cons_buf[g];
    end else begin : g_out
      assign cpu_ready[g]    = pair_avail[g];
      assign usb_ready[g]    = pair_space[g];
      assign PAIR_CPU_BUF[g] = cons_buf[g];
      assign PAIR_USB_BUF[g] = prod_buf[g];
    end
  end

  // Enable bit of the endpoint named by the token.
  always_comb begin
    ep_enabled = 1'b1;
    if (!TOK.ep[3]) begin
      ep_enabled = TOK.is_in ? st.bulk_in[TOK.ep[2:0]] : st.bulk_out[TOK.ep[2:0]];
    end else if (TOK.is_in) begin
      ep_enabled = st.iso_in[TOK.ep[2:0]];
    end
  end

  // Write strobes decoded per register.
  always_comb begin
    wsel    = 8'h00;
    wsel[0] = REG_WR && (REG_ADDR[15:0] == `UGC_ADDR_TOGGLE_CTL);
    wsel[1] = REG_WR && (REG_ADDR[15:0] == `UGC_ADDR_PAIR_CTL);
    wsel[2] = REG_WR && (REG_ADDR[15:0] == `UGC_ADDR_BULK_IN_EN);
    wsel[3] = REG_WR && (REG_ADDR[15:0] == `UGC_ADDR_BULK_OUT_EN);
    wsel[4] = REG_WR && (REG_ADDR[15:0] == `UGC_ADDR_ISO_IN_EN);
  end

  // Next-state logic for every register and output.
  always_comb begin
    next_st = st;

    // Frame number: a received marker loads, a missed one counts on.
    if (SOF.valid) begin
      next_st.frame = SOF.frame; // [RQ3]
    end else if (SOF.missed) begin
      next_st.frame = st.frame + 11'h001; // [RQ5] [RQ6]
    end

    // Device address: a new assignment wins over a clear in the same cycle.
    if (ADDR_EVT.set_valid) begin
      next_st.dev_addr = ADDR_EVT.set_addr; // [RQ7]
    end else if (ADDR_EVT.renum) begin
      next_st.dev_addr = `UGC_RST_DEV_ADDR; // [RQ9]
    end

    // Software-written control registers.
    if (wsel[1]) begin
      next_st.pair_ctl = REG_WDATA; // [RQ12] [RQ13]
    end
    if (wsel[2]) begin
      next_st.bulk_in = REG_WDATA;
    end
    if (wsel[3]) begin
      next_st.bulk_out = REG_WDATA;
    end
    if (wsel[4]) begin
      next_st.iso_in = REG_WDATA;
    end

    // Toggle control: select fields are stored, set and clear become one-cycle pulses.
    next_st.tog.set   = 1'b0;
    next_st.tog.clear = 1'b0;
    if (wsel[0]) begin
      next_st.tog_dir   = REG_WDATA[`UGC_TOG_DIR_BIT]; // [RQ2]
      next_st.tog_ep    = REG_WDATA[2:0]; // [RQ1]
      next_st.tog.clear = REG_WDATA[`UGC_TOG_CLR_BIT];
      next_st.tog.set   = REG_WDATA[`UGC_TOG_SET_BIT] && !REG_WDATA[`UGC_TOG_CLR_BIT];
      next_st.tog.is_in = REG_WDATA[`UGC_TOG_DIR_BIT]; // [RQ2]
      next_st.tog.ep    = REG_WDATA[2:0]; // [RQ1]
    end

    // Token verdict, one cycle after the token.
    next_st.resp.done = TOK.valid;
    if (TOK.valid) begin
      if (TOK.addr != st.dev_addr) begin
        next_st.resp.kind = ugc_pkg::UGC_RESP_IGNORE; // [RQ8]
      end else if (!ep_enabled) begin
        next_st.resp.kind = ugc_pkg::UGC_RESP_SILENT; // [RQ17]
      end else if (TOK.is_in && TOK.ep[3] && TOK.fifo_empty) begin
        if (st.pair_ctl[`UGC_PAIR_ZLP_BIT]) begin
          next_st.resp.kind = ugc_pkg::UGC_RESP_ZLP; // [RQ11]
        end else begin
          next_st.resp.kind = ugc_pkg::UGC_RESP_SILENT; // [RQ10]
        end
      end else begin
        next_st.resp.kind = ugc_pkg::UGC_RESP_NORMAL;
      end
    end

    // Even endpoint status for paired endpoints, shaped like a single buffer.
    next_st.busy = ~cpu_ready; // [RQ14]
    next_st.irq  = cpu_ready & st.busy & st.pair_ctl[5:0]; // [RQ14]
    next_st.nak  = ~usb_ready;

    // Read data stands for the one cycle after the read strobe.
    next_st.rdata = 8'h00;
    if (REG_RD) begin
      case (REG_ADDR[15:0])
        `UGC_ADDR_TOGGLE_CTL: begin
          next_st.rdata = {TOGGLE_VALUE, 2'h0, st.tog_dir, 1'b0, st.tog_ep};
        end
        `UGC_ADDR_FRAME_LOW: begin
          next_st.rdata = st.frame[7:0]; // [RQ4]
        end
        `UGC_ADDR_FRAME_HIGH: begin
          next_st.rdata = {5'h00, st.frame[10:8]}; // [RQ4]
        end
        `UGC_ADDR_DEV_ADDR: begin
          next_st.rdata = {1'b0, st.dev_addr}; // [RQ7]
        end
        `UGC_ADDR_PAIR_CTL: begin
          next_st.rdata = st.pair_ctl;
        end
        `UGC_ADDR_BULK_IN_EN: begin
          next_st.rdata = st.bulk_in;
        end
        `UGC_ADDR_BULK_OUT_EN: begin
          next_st.rdata = st.bulk_out;
        end
        `UGC_ADDR_ISO_IN_EN: begin
          next_st.rdata = st.iso_in;
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
  end

  // State register with synchronous reset to the default configuration.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      st          <= '0;
      st.frame    <= `UGC_RST_FRAME;
      st.dev_addr <= `UGC_RST_DEV_ADDR;
      st.pair_ctl <= `UGC_RST_PAIR_CTL;
      st.bulk_in  <= `UGC_RST_BULK_IN_EN; // [RQ18]
      st.bulk_out <= `UGC_RST_BULK_OUT_EN; // [RQ18]
      st.iso_in   <= `UGC_RST_ISO_IN_EN; // [RQ18]
      st.busy     <= 6'h3f;
      st.nak      <= 6'h3f;
    end else begin
      st <= next_st;
    end
  end

  // Outputs taken straight from the state register.
  assign REG_RDATA     = st.rdata;
  assign RESP          = st.resp;
  assign TOGGLE        = st.tog;
  assign PAIR_CPU_BUSY = st.busy;
  assign PAIR_CPU_IRQ  = st.irq;
  assign PAIR_USB_NAK  = st.nak;

endmodule

// ---- ugc_global_ctl_properties.sv ----
`timescale 1ns/100ps
module ugc_global_ctl_properties #(
  parameter int ADDR_W = 16
) (
  // Clock and reset.
  input wire logic                   CORE_CLK,
  input wire logic                   RST_N,
  // Register port.
  input wire logic [ADDR_W-1:0]      REG_ADDR,
  input wire logic [7:0]             REG_WDATA,
  input wire logic                   REG_WR,
  input wire logic                   REG_RD,
  input wire logic [7:0]             REG_RDATA,
  // Host events, verdicts and status.
  input wire ugc_pkg::ugc_sof_t      SOF,
  input wire ugc_pkg::ugc_addr_evt_t ADDR_EVT,
  input wire ugc_pkg::ugc_tok_t      TOK,
  input wire ugc_pkg::ugc_resp_t     RESP,
  input wire logic [5:0]             PAIR_CPU_BUSY,
  input wire logic [5:0]             PAIR_CPU_IRQ,
  input wire ugc_pkg::ugc_tog_t      TOGGLE
);
  logic [10:0] frame; // Frame count the device should hold.
  logic [6:0]  own;   // Address the device should answer to.
  logic        zlp;    // Zero-length reply flag as software last wrote it.
  logic [7:0]  iso_en; // Iso IN enables as software last wrote them.
  ugc_pkg::ugc_resp_kind_t iso_exp; // Verdict owed to an empty iso IN token of the previous cycle.
  // Follow frame markers, address events and software settings independently of the design.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      frame   <= 11'h000;
      own     <= 7'h00;
      zlp     <= 1'b0;
      iso_en  <= 8'h07;
      iso_exp <= ugc_pkg::UGC_RESP_SILENT;
    end else begin
      if (SOF.valid) frame <= SOF.frame;
      else if (SOF.missed) frame <= frame + 11'h001;
      if (ADDR_EVT.set_valid) own <= ADDR_EVT.set_addr;
      else if (ADDR_EVT.renum) own <= 7'h00;
      if (REG_WR && REG_ADDR == 16'h7fdd) zlp <= REG_WDATA[7];
      if (REG_WR && REG_ADDR == 16'h7fe0) iso_en <= REG_WDATA;
      // A disabled endpoint stays silent even when the zero-length reply is on.
      iso_exp <= (zlp && iso_en[TOK.ep[2:0]]) ? ugc_pkg::UGC_RESP_ZLP : ugc_pkg::UGC_RESP_SILENT;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  a_rdata_idle: assert property (
    !REG_RD |=> REG_RDATA == 8'h00) else $error("read data not zero when idle");
  a_frame_low: assert property (
    REG_RD && REG_ADDR == 16'h7fd8 |=> REG_RDATA == $past(frame[7:0])) else $error("frame low wrong");
  a_frame_high: assert property (
    REG_RD && REG_ADDR == 16'h7fd9 |=> REG_RDATA == {5'h00, $past(frame[10:8])}) else $error("frame high wrong");
  a_addr_read: assert property (
    REG_RD && REG_ADDR == 16'h7fdb |=> REG_RDATA == {1'b0, $past(own)}) else $error("address wrong");
  a_resp_next: assert property (
    TOK.valid |=> RESP.done) else $error("no verdict after token");
  a_resp_quiet: assert property (
    !TOK.valid |=> !RESP.done) else $error("verdict without token");
  a_foreign_ignored: assert property (
    TOK.valid && TOK.addr != own |=> RESP.kind == ugc_pkg::UGC_RESP_IGNORE) else $error("foreign token answered");
  a_iso_empty: assert property (
    TOK.valid && TOK.addr == own && TOK.is_in && TOK.ep[3] && TOK.fifo_empty
    |=> RESP.kind == iso_exp) else $error("empty iso reply wrong");
  a_toggle_clear: assert property (
    REG_WR && REG_ADDR == 16'h7fd7 && REG_WDATA[5] |=> TOGGLE.clear && !TOGGLE.set
    && {3'b000, TOGGLE.is_in, 1'b0, TOGGLE.ep} == ($past(REG_WDATA) & 8'h17)) else $error("toggle clear wrong");
  a_irq_on_fall: assert property (
    (PAIR_CPU_IRQ & ~($past(PAIR_CPU_BUSY) & ~PAIR_CPU_BUSY)) == 6'h00) else $error("irq without busy fall");
  c_zlp: cover property (RESP.done && RESP.kind == ugc_pkg::UGC_RESP_ZLP);
  c_missed: cover property (SOF.missed);
  c_irq: cover property (PAIR_CPU_IRQ != 6'h00);
endmodule
bind ugc_global_ctl ugc_global_ctl_properties #(.ADDR_W(ADDR_W)) u_props (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SOF(SOF), .ADDR_EVT(ADDR_EVT),
  .TOK(TOK), .RESP(RESP), .PAIR_CPU_BUSY(PAIR_CPU_BUSY), .PAIR_CPU_IRQ(PAIR_CPU_IRQ), .TOGGLE(TOGGLE));

// ---- ugc_host_model.sv ----
`timescale 1ns/100ps
module ugc_host_model (
  // Clock.
  input  wire logic              clk,
  // Host traffic as the decoder reports it.
  output ugc_pkg::ugc_sof_t      sof,
  output ugc_pkg::ugc_addr_evt_t addr_evt,
  output ugc_pkg::ugc_tok_t      tok,
  output ugc_pkg::ugc_ep_evt_t   xfer,
  // Verdict from the device.
  input  wire ugc_pkg::ugc_resp_t resp
);
  // Quiet lines at time zero.
  initial begin
    sof      = '0;
    addr_evt = '0;
    tok      = '0;
    xfer     = '0;
  end
  // A frame marker, received or missed; idle fields are inverted afterwards.
  task automatic frame_mark(input logic miss, input logic [10:0] num);
    @(posedge clk);
    sof <= '{valid: !miss, missed: miss, frame: num};
    @(posedge clk);
    sof <= '{valid: 1'b0, missed: 1'b0, frame: ~num};
  endtask
  // An address assignment or a re-enumeration.
  task automatic addr_event(input logic set, input logic [6:0] a, input logic re);
    @(posedge clk);
    addr_evt <= '{set_valid: set, set_addr: a, renum: re};
    @(posedge clk);
    addr_evt <= '{set_valid: 1'b0, set_addr: ~a, renum: 1'b0};
  endtask
  // A token; returns done and kind seen one cycle after it is taken.
  task automatic token(input logic [6:0] a, input logic [3:0] n, input logic in, input logic e,
                       output logic [2:0] r);
    @(posedge clk);
    tok <= '{valid: 1'b1, addr: a, ep: n, is_in: in, fifo_empty: e};
    @(posedge clk);
    tok <= '{valid: 1'b0, addr: ~a, ep: ~n, is_in: !in, fifo_empty: !e};
    #1 r = {resp.done, resp.kind};
  endtask
  // A finished bulk transfer on the bus.
  task automatic xfer_done(input logic in, input logic [2:0] n);
    @(posedge clk);
    xfer <= '{valid: 1'b1, is_in: in, ep: n};
    @(posedge clk);
    xfer <= '{valid: 1'b0, is_in: !in, ep: ~n};
  endtask
endmodule

// ---- ugc_global_ctl_tb_top.sv ----
`timescale 1ns/100ps
module ugc_global_ctl_tb_top;
  localparam logic [1:0] IGN = ugc_pkg::UGC_RESP_IGNORE;
  localparam logic [1:0] SIL = ugc_pkg::UGC_RESP_SILENT;
  localparam logic [1:0] ZLP = ugc_pkg::UGC_RESP_ZLP;
  localparam logic [1:0] NRM = ugc_pkg::UGC_RESP_NORMAL;
  logic                   CORE_CLK = 1'b0;     // Core clock.
  logic                   RST_N = 1'b0;        // Reset, active low.
  logic [15:0]            REG_ADDR = 16'h0000; // Register address.
  logic [7:0]             REG_WDATA = 8'h00;   // Write data.
  logic                   REG_WR = 1'b0;       // Write strobe.
  logic                   REG_RD = 1'b0;       // Read strobe.
  logic                   togv = 1'b0;         // Toggle value fed back.
  ugc_pkg::ugc_ep_evt_t   bcw = '0;            // Byte count writes.
  logic [7:0]             rdata;               // Read data.
  logic [5:0]             busy, irq, nak;      // Pair status.
  logic [5:0]             cbuf, ubuf;          // Buffer index on the CPU and USB sides.
  ugc_pkg::ugc_sof_t      sof;
  ugc_pkg::ugc_addr_evt_t aev;
  ugc_pkg::ugc_tok_t      tok;
  ugc_pkg::ugc_ep_evt_t   xfer;
  ugc_pkg::ugc_resp_t     resp;
  ugc_pkg::ugc_tog_t      tog;
  int                     num_errors = 0;
  int                     samples_checked = 0;
  logic [15:0] ra [8] = '{16'h7fd8, 16'h7fd9, 16'h7fdb, 16'h7fdd, 16'h7fde, 16'h7fdf, 16'h7fe0, 16'h7fe3};
  logic [7:0]  rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h57, 8'h55, 8'h07, 8'h00};
  // Free-running 50 MHz clock.
  always #10 CORE_CLK = ~CORE_CLK;
  ugc_host_model host (.clk(CORE_CLK), .sof(sof), .addr_evt(aev), .tok(tok), .xfer(xfer), .resp(resp));
  ugc_global_ctl uut (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(rdata), .SOF(sof), .ADDR_EVT(aev), .TOK(tok), .RESP(resp),
    .XFER_DONE(xfer), .BC_WRITE(bcw), .PAIR_CPU_BUSY(busy), .PAIR_CPU_IRQ(irq), .PAIR_USB_NAK(nak),
    .PAIR_CPU_BUF(cbuf), .PAIR_USB_BUF(ubuf), .TOGGLE_VALUE(togv), .TOGGLE(tog));
  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle register write.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
    REG_WDATA <= ~d;
  endtask
  // One-cycle register read, data compared in the following cycle.
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge CORE_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    REG_ADDR <= ~a;
    #1 chk(rdata, exp);
  endtask
  // Token through the host with the expected verdict.
  task automatic tk(input logic [6:0] a, input logic [3:0] n, input logic in, input logic e, input logic [1:0] k);
    logic [2:0] r;
    host.token(a, n, in, e, r);
    chk({5'h00, r}, {6'h01, k});
  endtask
  // Byte count write pulse from the processor side.
  task automatic bc(input logic in, input logic [2:0] n);
    @(posedge CORE_CLK);
    bcw <= '{valid: 1'b1, is_in: in, ep: n};
    @(posedge CORE_CLK);
    bcw <= '{valid: 1'b0, is_in: !in, ep: ~n};
  endtask
  // Pair status two cycles after the event edge.
  task automatic pc(input logic [5:0] eb, input logic [5:0] en);
    @(posedge CORE_CLK);
    #1 chk({2'b00, busy}, {2'b00, eb});
    chk({2'b00, nak}, {2'b00, en});
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (2) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
    wr(16'h7fd8, 8'hff);
    wr(16'h7fdb, 8'hff);
    rd(16'h7fd8, 8'h00);
    rd(16'h7fdb, 8'h00);
    host.frame_mark(1'b0, 11'h7fe);
    rd(16'h7fd8, 8'hfe);
    rd(16'h7fd9, 8'h07);
    host.frame_mark(1'b1, 11'h123);
    rd(16'h7fd8, 8'hff);
    host.frame_mark(1'b1, 11'h123);
    rd(16'h7fd8, 8'h00);
    rd(16'h7fd9, 8'h00);
    host.addr_event(1'b1, 7'h5a, 1'b0);
    rd(16'h7fdb, 8'h5a);
    tk(7'h00, 4'h0, 1'b1, 1'b0, IGN);
    tk(7'h5a, 4'h0, 1'b1, 1'b0, NRM);
    tk(7'h5a, 4'h3, 1'b1, 1'b0, SIL);
    tk(7'h5a, 4'h1, 1'b0, 1'b0, SIL);
    tk(7'h5a, 4'h6, 1'b0, 1'b0, NRM);
    tk(7'h5a, 4'hb, 1'b1, 1'b0, SIL);
    tk(7'h5a, 4'h8, 1'b1, 1'b1, SIL);
    tk(7'h5a, 4'h8, 1'b1, 1'b0, NRM);
    wr(16'h7fdd, 8'h89);
    wr(16'h7fe0, 8'hff);
    rd(16'h7fdd, 8'h89);
    tk(7'h5a, 4'h8, 1'b1, 1'b1, ZLP);
    tk(7'h5a, 4'hf, 1'b1, 1'b1, ZLP);
    host.addr_event(1'b0, 7'h5a, 1'b1);
    rd(16'h7fdb, 8'h00);
    tk(7'h00, 4'h0, 1'b0, 1'b0, NRM);
    @(posedge CORE_CLK) togv <= 1'b1;
    wr(16'h7fd7, 8'h75);
    #1 chk({2'b00, tog}, 8'h1d);
    wr(16'h7fd7, 8'h43);
    #1 chk({2'b00, tog}, 8'h23);
    rd(16'h7fd7, 8'h83);
    host.xfer_done(1'b0, 3'h2);
    pc(6'h30, 6'h07);
    chk({2'b00, irq}, 8'h08);
    chk({2'b00, ubuf}, 8'h08);
    chk({2'b00, cbuf}, 8'h00);
    host.xfer_done(1'b0, 3'h3);
    pc(6'h30, 6'h07);
    host.xfer_done(1'b0, 3'h2);
    pc(6'h30, 6'h0f);
    bc(1'b0, 3'h2);
    pc(6'h30, 6'h07);
    chk({2'b00, irq}, 8'h00);
    chk({2'b00, cbuf}, 8'h08);
    chk({2'b00, ubuf}, 8'h00);
    bc(1'b0, 3'h2);
    pc(6'h38, 6'h07);
    bc(1'b1, 3'h2);
    pc(6'h38, 6'h06);
    bc(1'b1, 3'h2);
    pc(6'h39, 6'h06);
    host.xfer_done(1'b1, 3'h2);
    pc(6'h38, 6'h06);
    chk({2'b00, irq}, 8'h01);
    chk({2'b00, cbuf}, 8'h00);
    chk({2'b00, ubuf}, 8'h01);
    report_and_stop();
  end
  // Watchdog against a hung handshake.
  initial begin
    repeat (3000) @(posedge CORE_CLK);
    num_errors++;
    report_and_stop();
  end
endmodule
